/* File: periodic_timer_defines.svh */
// Purpose: offsets, field positions and reset values of the periodic timer
// Assumes: 32-bit wishbone data, byte addressing, word aligned registers
// Notes: shared by every design file of the timer except the type package
`ifndef PERIODIC_TIMER_DEFINES_SVH
`define PERIODIC_TIMER_DEFINES_SVH

`define PT_CHANNELS 2
`define PT_ADR_W 12
`define PT_DATA_W 32

// register byte offsets
`define PT_MCR_OFS 12'h000
`define PT_LIFE_HI_OFS 12'h0e0
`define PT_LIFE_LO_OFS 12'h0e4
`define PT_IRQ_MASK_OFS 12'h0f0
`define PT_IRQ_STAT_OFS 12'h0f4
`define PT_CH_PAGE 4'h1
`define PT_LDV_SEL 2'h0
`define PT_CVAL_SEL 2'h1
`define PT_CTRL_SEL 2'h2
`define PT_FLG_SEL 2'h3

// field positions
`define PT_MODULE_DISABLE_BIT 1
`define PT_TEN_BIT 0
`define PT_TIE_BIT 1
`define PT_CHN_BIT 2
`define PT_TIF_BIT 0

// reset values
`define PT_MCR_RST 32'h0000_0002
`define PT_LDV_RST 32'h0000_0000
`define PT_MASK_RST 2'h3
`define PT_ZERO 32'h0000_0000

`endif

/* File: periodic_timer_pkg.sv */
// Purpose: types shared by the periodic timer design files
// Assumes: two channels
// Notes: constants live in periodic_timer_defines.svh
package periodic_timer_pkg;

    // channel counter state
    typedef enum logic [1:0] {
        ch_idle = 2'b01,
        ch_run = 2'b10
    } chan_state_e;

    // per channel control word
    typedef struct packed {
        logic chain_mode;
        logic timer_irq_enable;
        logic timer_enable_bit;
    } channel_control_s;

endpackage

/* File: timer_channel.sv */
// Purpose: one downcounting timer channel with reload and trigger
// Assumes: load value stable or changed only between expiries
// Notes: trigger is a one-cycle pulse at each expiry
`timescale 1ns/1ns
`include "periodic_timer_defines.svh"
module timer_channel (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic active,
    input wire logic chained,
    input wire logic prev_tick,
    input wire logic [`PT_DATA_W-1:0] load_value,
    // status
    output logic [`PT_DATA_W-1:0] count,
    output logic tick
);
    periodic_timer_pkg::chan_state_e state_r;
    logic step;

    // chained channels step on the previous expiry only
    assign step = chained ? prev_tick : 1'b1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= periodic_timer_pkg::ch_idle;
            count <= `PT_ZERO;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            case (state_r)
                periodic_timer_pkg::ch_idle: begin
                    if (active) begin
                        count <= load_value;
                        state_r <= periodic_timer_pkg::ch_run;
                    end
                end
                periodic_timer_pkg::ch_run: begin
                    if (!active) begin
                        state_r <= periodic_timer_pkg::ch_idle;
                    end else if (step) begin
                        if (count == `PT_ZERO) begin
                            count <= load_value;
                            tick <= 1'b1;
                        end else begin
                            count <= count - 32'h0000_0001;
                        end
                    end
                end
                default: begin
                    state_r <= periodic_timer_pkg::ch_idle;
                end
            endcase
        end
    end
endmodule

/* File: timer_flag_bank.sv */
// Purpose: sticky timeout flags, write-one-to-clear, interrupt merge
// Assumes: set and clear may arrive in the same cycle
// Notes: a set in the clear cycle wins
`timescale 1ns/1ns
`include "periodic_timer_defines.svh"
module timer_flag_bank (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // events and clears
    input wire logic [`PT_CHANNELS-1:0] set,
    input wire logic [`PT_CHANNELS-1:0] clr,
    // gating
    input wire logic [`PT_CHANNELS-1:0] irq_en,
    input wire logic [`PT_CHANNELS-1:0] mask,
    // results
    output logic [`PT_CHANNELS-1:0] flags,
    output logic irq
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clr) | set;
        end
    end

    // level output, held while any enabled flag stands
    assign irq = |(flags & irq_en & mask);
endmodule

/* File: periodic_timer.sv */
// Purpose: two-channel periodic timer with chaining and lifetime view
// Assumes: classic wishbone slave, one clock, asynchronous reset
// Notes: every access is answered one cycle after the request
//
// Overview of operation
// - the timer stays idle until software writes 0 to the module_disable bit.
// - the expiry period of an unchained channel in clocks is the load value plus one.
// - setting timer_enable_bit starts the channel from its load value.
// - with timer_irq_enable at 0 the channel still emits trigger pulses.
// - each channel counter decrements from the load value toward zero.
// - a chained channel decrements once per expiry of the channel before it.
// - the lifetime value reads as an upper and a lower word, upper first.
// - at zero a channel pulses its trigger, sets its flag and reloads.
// - writing 1 clears a timeout flag, and a set flag with enable and its mask bit at 1 interrupts.
// - channel 0 ignores chain_mode.
`timescale 1ns/1ns
`include "periodic_timer_defines.svh"
module periodic_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`PT_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [`PT_DATA_W-1:0] wb_dat_i,
    output logic [`PT_DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // timer outputs
    output logic [`PT_CHANNELS-1:0] trigger_o,
    output logic irq_o
);

////////////////////////////////////////////////////////////////////////////////
// helpers

    // merge write data into a word under byte enables
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // true when an address falls in the channel page of a given channel
    function automatic logic chan_hit(
        input logic [`PT_ADR_W-1:0] adr,
        input int unsigned ch
    );
        logic hit;
        hit = (adr[11:8] == `PT_CH_PAGE) && (adr[7:5] == 3'h0);
        return hit && (adr[4] == ch[0]);
    endfunction

////////////////////////////////////////////////////////////////////////////////
// bus handshake

    logic req;
    logic ack_r;
    logic wr_go;
    logic rd_go;
    logic [`PT_ADR_W-1:0] adr_w;
    logic [1:0] ch_sel;

    assign req = wb_cyc_i & wb_stb_i;
    // writes land on the edge where the master samples ack
    assign wr_go = req & wb_we_i & ack_r;
    // read data is latched as ack rises
    assign rd_go = req & ~wb_we_i & ~ack_r;
    assign adr_w = {wb_adr_i[11:2], 2'b00};
    assign ch_sel = adr_w[3:2];
    assign wb_ack_o = ack_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// module control

    logic [`PT_DATA_W-1:0] mcr_r;
    logic module_disable;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mcr_r <= `PT_MCR_RST;
        end else if (wr_go && adr_w == `PT_MCR_OFS && wb_sel_i[0]) begin
            mcr_r <= {30'h0000_0000, wb_dat_i[`PT_MODULE_DISABLE_BIT], 1'b0};
        end
    end

    assign module_disable = mcr_r[`PT_MODULE_DISABLE_BIT];

////////////////////////////////////////////////////////////////////////////////
// interrupt mask

    logic [`PT_CHANNELS-1:0] irq_mask_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_r <= `PT_MASK_RST;
        end else if (wr_go && adr_w == `PT_IRQ_MASK_OFS && wb_sel_i[0]) begin
            irq_mask_r <= wb_dat_i[`PT_CHANNELS-1:0];
        end
    end

////////////////////////////////////////////////////////////////////////////////
// per channel registers and counters

    logic [`PT_DATA_W-1:0] load_value [`PT_CHANNELS];
    periodic_timer_pkg::channel_control_s channel_control [`PT_CHANNELS];
    logic [`PT_DATA_W-1:0] count [`PT_CHANNELS];
    logic [`PT_CHANNELS-1:0] tick;
    logic [`PT_CHANNELS-1:0] tie_vec;
    logic [`PT_CHANNELS-1:0] flag_clr;
    logic [`PT_CHANNELS-1:0] timeout_flag;
    logic stat_wr;

    assign stat_wr = wr_go && adr_w == `PT_IRQ_STAT_OFS && wb_sel_i[0];

    for (genvar c = 0; c < `PT_CHANNELS; c++) begin : g_ch
        logic ldv_wr;
        logic ctrl_wr;
        logic flg_wr;
        logic prev;
        logic chained;

        assign ldv_wr = wr_go && chan_hit(adr_w, c) && ch_sel == `PT_LDV_SEL;
        assign ctrl_wr = wr_go && chan_hit(adr_w, c) && ch_sel == `PT_CTRL_SEL;
        assign flg_wr = wr_go && chan_hit(adr_w, c) && ch_sel == `PT_FLG_SEL;

        // new load value is picked up at the next start from idle or the next reload
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                load_value[c] <= `PT_LDV_RST;
            end else if (ldv_wr) begin
                load_value[c] <= merge_bytes(load_value[c], wb_dat_i, wb_sel_i);
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                channel_control[c] <= '0;
            end else if (ctrl_wr && wb_sel_i[0]) begin
                channel_control[c].timer_enable_bit <= wb_dat_i[`PT_TEN_BIT];
                channel_control[c].timer_irq_enable <= wb_dat_i[`PT_TIE_BIT];
                // channel 0 has nothing to chain to
                channel_control[c].chain_mode <= (c != 0) && wb_dat_i[`PT_CHN_BIT];
            end
        end

        if (c == 0) begin : g_first
            assign prev = 1'b0;
            assign chained = 1'b0;
        end else begin : g_next
            assign prev = tick[c-1];
            assign chained = channel_control[c].chain_mode;
        end

        assign tie_vec[c] = channel_control[c].timer_irq_enable;
        // write one to clear, through the flag or the status alias
        assign flag_clr[c] = (flg_wr && wb_sel_i[0] && wb_dat_i[`PT_TIF_BIT]) ||
                             (stat_wr && wb_dat_i[c]);

        timer_channel u_chan (
            .clk(clk),
            .rst_n(rst_n),
            .active(channel_control[c].timer_enable_bit & ~module_disable),
            .chained(chained),
            .prev_tick(prev),
            .load_value(load_value[c]),
            .count(count[c]),
            .tick(tick[c])
        );
    end

    // triggers run regardless of interrupt enable
    assign trigger_o = tick;

////////////////////////////////////////////////////////////////////////////////
// timeout flags and interrupt

    timer_flag_bank u_flags (
        .clk(clk),
        .rst_n(rst_n),
        .set(tick),
        .clr(flag_clr),
        .irq_en(tie_vec),
        .mask(irq_mask_r),
        .flags(timeout_flag),
        .irq(irq_o)
    );

////////////////////////////////////////////////////////////////////////////////
// lifetime snapshot

    logic [`PT_DATA_W-1:0] life_lo_snap_r;
    logic life_hi_rd;

    assign life_hi_rd = rd_go && adr_w == `PT_LIFE_HI_OFS;

    // upper read freezes the lower half for the following lower read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            life_lo_snap_r <= `PT_ZERO;
        end else if (life_hi_rd) begin
            life_lo_snap_r <= count[0];
        end
    end

////////////////////////////////////////////////////////////////////////////////
// read data

    logic [`PT_DATA_W-1:0] rdata;

    always_comb begin
        rdata = `PT_ZERO;
        if (adr_w == `PT_MCR_OFS) begin
            rdata = mcr_r;
        end else if (adr_w == `PT_LIFE_HI_OFS) begin
            rdata = count[1];
        end else if (adr_w == `PT_LIFE_LO_OFS) begin
            rdata = life_lo_snap_r;
        end else if (adr_w == `PT_IRQ_MASK_OFS) begin
            rdata[`PT_CHANNELS-1:0] = irq_mask_r;
        end else if (adr_w == `PT_IRQ_STAT_OFS) begin
            rdata[`PT_CHANNELS-1:0] = timeout_flag;
        end else begin
            for (int c = 0; c < `PT_CHANNELS; c++) begin
                if (chan_hit(adr_w, c)) begin
                    case (ch_sel)
                        `PT_LDV_SEL: begin
                            rdata = load_value[c];
                        end
                        `PT_CVAL_SEL: begin
                            rdata = count[c];
                        end
                        `PT_CTRL_SEL: begin
                            rdata[`PT_TEN_BIT] = channel_control[c].timer_enable_bit;
                            rdata[`PT_TIE_BIT] = channel_control[c].timer_irq_enable;
                            rdata[`PT_CHN_BIT] = channel_control[c].chain_mode;
                        end
                        `PT_FLG_SEL: begin
                            rdata[`PT_TIF_BIT] = timeout_flag[c];
                        end
                        default: begin
                            rdata = `PT_ZERO;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= `PT_ZERO;
        end else if (rd_go) begin
            wb_dat_o <= rdata;
        end
    end

endmodule

/* File: periodic_timer_assertions.sv */
// Purpose: bus, enable and interrupt checks on the timer ports
// Assumes: one clock, asynchronous active low reset
// Notes: bound from the testbench top file
`timescale 1ns/1ns
`include "periodic_timer_defines.svh"
module periodic_timer_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`PT_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [`PT_DATA_W-1:0] wb_dat_i,
    input wire logic [`PT_DATA_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    // timer
    input wire logic [`PT_CHANNELS-1:0] trigger_o,
    input wire logic irq_o
);
    logic wr;
    logic dis_r;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    // shadow of module_disable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dis_r <= 1'b1;
        end else if (wr && wb_adr_i == `PT_MCR_OFS) begin
            dis_r <= wb_dat_i[`PT_MODULE_DISABLE_BIT];
        end
    end
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_wr(a, d);
        wr && wb_adr_i == a && wb_dat_i[1:0] == d;
    endsequence
    property p_ack_resp;
        s_req |=> wb_ack_o;
    endproperty
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_ack_idle;
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
    endproperty
    property p_module_disable_quiet;
        dis_r [*3] |-> trigger_o == 2'h0;
    endproperty
    property p_unmapped;
        s_req ##0 (!wb_we_i && wb_adr_i == 12'h004) |=> wb_dat_o == `PT_ZERO;
    endproperty
    property p_dat_hold;
        !(wb_cyc_i && wb_stb_i && !wb_we_i) |=> $stable(wb_dat_o);
    endproperty
    property p_irq_clear;
        s_wr(`PT_IRQ_STAT_OFS, 2'h3) ##0 (trigger_o == 2'h0) |=> !irq_o;
    endproperty
    property p_mask_off;
        s_wr(`PT_IRQ_MASK_OFS, 2'h0) |=> !irq_o [*2];
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("ack late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
    a_module_disable_quiet: assert property (p_module_disable_quiet) else $error("trigger while off");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
    a_irq_clear: assert property (p_irq_clear) else $error("irq after clear");
    a_mask_off: assert property (p_mask_off) else $error("irq while masked");
endmodule

/* File: test_periodic_timer.sv */
// Purpose: register level test of the periodic timer
// Assumes: each access answered one cycle after request
// Notes: a monitor records trigger gaps per channel
`timescale 1ns/1ns
module test_periodic_timer;
    logic clk, rst_n, cyc, stb, we, ack, irq;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, dout, v;
    logic [1:0] trig;
    int failures, checked, cyc_n;
    int last_t[2], gap[2], cnt[2];
    periodic_timer dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout),
        .wb_ack_o(ack), .trigger_o(trig), .irq_o(irq));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc_n++;
        for (int i = 0; i < 2; i++) begin
            if (trig[i] === 1'b1) begin
                gap[i] = cyc_n - last_t[i];
                last_t[i] = cyc_n;
                cnt[i]++;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // look at ack once it has settled, then act on the edge that samples it
        @(negedge clk);
        while (ack !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
        chk("ack", 1'b1, n < 50);
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
    initial begin
        {rst_n, cyc, stb, we, adr, sel, wdat} = '0;
        sel = 4'hf;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(0, 12'h000, 0); chk("mcr", 32'h2, rdat);
        bus(0, 12'h0f0, 0); chk("mask", 32'h3, rdat);
        bus(0, 12'h004, 0); chk("unmapped", 32'h0, rdat);
        bus(0, 12'h108, 0); chk("ctrl0", 32'h0, rdat);
        bus(1, 12'h100, 4);
        bus(1, 12'h108, 1);
        repeat (20) @(posedge clk);
        chk("idle trig", 0, cnt[0]);
        bus(1, 12'h000, 0);
        repeat (30) @(posedge clk);
        chk("period", 5, gap[0]);
        bus(1, 12'h10c, 0);
        bus(0, 12'h10c, 0); chk("flag", 1, rdat);
        chk("no irq", 0, irq);
        bus(1, 12'h100, 9);
        repeat (30) @(posedge clk);
        chk("new load", 10, gap[0]);
        bus(1, 12'h108, 3); chk("irq on", 1, irq);
        bus(1, 12'h0f0, 0); chk("masked", 0, irq);
        bus(1, 12'h0f0, 3);
        bus(1, 12'h108, 2);
        repeat (3) @(posedge clk);
        bus(1, 12'h10c, 1); chk("cleared", 0, irq);
        bus(0, 12'h10c, 0); chk("flag clr", 0, rdat);
        bus(1, 12'h100, 1000);
        bus(1, 12'h108, 1);
        bus(0, 12'h104, 0);
        v = rdat;
        bus(0, 12'h104, 0); chk("down", 1, rdat < v && v <= 1000);
        repeat (50) @(posedge clk);
        bus(1, 12'h108, 0);
        bus(0, 12'h104, 0);
        v = rdat;
        repeat (5) @(posedge clk);
        bus(0, 12'h104, 0); chk("stopped", v, rdat);
        bus(1, 12'h108, 1);
        bus(0, 12'h104, 0); chk("restart", 1, rdat >= 990 && v < 960);
        bus(1, 12'h108, 0);
        bus(1, 12'h100, 4);
        bus(1, 12'h108, 5);
        bus(0, 12'h108, 0); chk("chain0", 1, rdat);
        bus(1, 12'h110, 2);
        bus(1, 12'h118, 7);
        repeat (80) @(posedge clk);
        chk("gap0", 5, gap[0]);
        chk("gap1", 15, gap[1]);
        chk("irq1", 1, irq);
        bus(1, 12'h118, 0);
        bus(1, 12'h108, 0);
        repeat (3) @(posedge clk);
        bus(1, 12'h0f4, 3); chk("stat clr", 0, irq);
        bus(1, 12'h110, 32'hffffffff);
        bus(1, 12'h118, 4);
        bus(1, 12'h118, 5);
        bus(1, 12'h100, 32'hffffffff);
        bus(1, 12'h108, 1);
        repeat (40) @(posedge clk);
        bus(0, 12'h0e0, 0); chk("upper", 32'hffffffff, rdat);
        repeat (20) @(posedge clk);
        bus(0, 12'h0e4, 0);
        v = rdat;
        bus(0, 12'h104, 0); chk("snap", 1, v > rdat + 20 && v > 32'hffffff00);
        tally_and_finish();
    end
endmodule
bind periodic_timer periodic_timer_checker chk_u (.clk(clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .trigger_o(trigger_o), .irq_o(irq_o));
